// *** logic/cks_pkg.sv ***
// Constants shared by the card information checksum checker
package cks_pkg;
	localparam int ADDR_W = 24;
	localparam logic [7:0] CHECKSUM_CODE = 8'h10;
	localparam logic [7:0] SUM_RESET = 8'h00;
	localparam logic [2:0] IDX_CODE = 3'h0;
	localparam logic [2:0] IDX_LINK = 3'h1;
	localparam logic [2:0] IDX_OFF_LO = 3'h2;
	localparam logic [2:0] IDX_OFF_HI = 3'h3;
	localparam logic [2:0] IDX_LEN_LO = 3'h4;
	localparam logic [2:0] IDX_LEN_HI = 3'h5;
	localparam logic [2:0] IDX_SUM = 3'h6;
	localparam int ENTRY_BYTES = 7;
	localparam logic [ADDR_W-1:0] STEP_COMMON = 24'h000001;
	localparam logic [ADDR_W-1:0] STEP_ATTR = 24'h000002;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 24'h000000;
	localparam logic [15:0] LEN_ZERO = 16'h0000;
	localparam logic [15:0] LEN_ONE = 16'h0001;
	typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_SUM, ST_DONE} cks_state_t;
endpackage

// *** logic/sum_accumulator.sv ***
// Modulo-256 byte accumulator
module sum_accumulator (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Control
	input wire logic i_clear,
	input wire logic i_add,
	input wire logic [7:0] i_data,
	// Result
	output logic [7:0] o_sum
);
	always_ff @(posedge i_mclk) begin
		if (i_rst || i_clear) begin
			o_sum <= cks_pkg::SUM_RESET;
		end else if (i_add) begin
			o_sum <= o_sum + i_data;
		end
	end
endmodule

// *** logic/card_info_checksum_checker.sv ***
// Checksum entry checker for card information structures
//
// Behaviour
// - Offset and length fields are assembled low byte first.
// - The region offset is a signed 16-bit value relative to entry start.
// - Negative offsets reach before the entry, positive ones after it.
// - The length field is an unsigned 16-bit byte count.
// - Selected bytes are summed with modulo-256 wraparound.
// - The sum is compared with the expected byte at entry position 6.
// - In common space the target is entry base plus signed offset.
// - Only the low 8 bits of the sum are compared.
// - Pass on equality, fail otherwise; a foreign entry code sets neither.
// - In attribute space the target is entry base plus twice the offset.
// - In attribute space only even bytes over twice the length are summed.
// - The region is read only from the entry's own address space.
// - Attribute space entry fields sit in even bytes; common uses every byte.
module card_info_checksum_checker (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Command
	input wire logic i_start,
	input wire logic [cks_pkg::ADDR_W-1:0] i_entry_addr,
	input wire logic i_attr_space,
	// Card memory read port
	output logic o_mem_req,
	output logic [cks_pkg::ADDR_W-1:0] o_mem_addr,
	output logic o_mem_attr,
	input wire logic i_mem_ack,
	input wire logic [7:0] i_mem_data,
	// Status
	output logic o_busy,
	output logic o_done,
	output logic o_pass,
	output logic o_fail,
	output logic o_bad_code,
	output logic [7:0] o_sum
);
	cks_pkg::cks_state_t state;
	logic space_attr;
	logic [cks_pkg::ADDR_W-1:0] base;
	logic [cks_pkg::ADDR_W-1:0] addr;
	logic [2:0] fidx;
	logic [15:0] remaining;
	logic mem_req;
	logic bad_code;
	logic [7:0] fields [0:cks_pkg::ENTRY_BYTES-1];
	logic [7:0] acc_sum;
	logic take;
	logic [15:0] off_field;
	logic [15:0] len_field;

	function automatic logic [cks_pkg::ADDR_W-1:0] step(
		input logic [cks_pkg::ADDR_W-1:0] a,
		input logic attr
	);
		step = a + (attr ? cks_pkg::STEP_ATTR : cks_pkg::STEP_COMMON);
	endfunction

	function automatic logic [cks_pkg::ADDR_W-1:0] target_addr(
		input logic [cks_pkg::ADDR_W-1:0] b,
		input logic [15:0] off,
		input logic attr
	);
		logic [cks_pkg::ADDR_W-1:0] ext;
		ext = {{(cks_pkg::ADDR_W-16){off[15]}}, off};
		target_addr = b + (attr ? {ext[cks_pkg::ADDR_W-2:0], 1'b0} : ext);
	endfunction

	assign take = mem_req && i_mem_ack;
	assign off_field = {fields[cks_pkg::IDX_OFF_HI], fields[cks_pkg::IDX_OFF_LO]};
	assign len_field = {fields[cks_pkg::IDX_LEN_HI], fields[cks_pkg::IDX_LEN_LO]};

	assign o_mem_req = mem_req;
	assign o_mem_addr = addr;
	assign o_mem_attr = space_attr;
	assign o_busy = (state != cks_pkg::ST_IDLE);
	assign o_sum = acc_sum;

	// Sequencer
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			state <= cks_pkg::ST_IDLE;
			space_attr <= 1'b0;
			base <= cks_pkg::ADDR_RESET;
			addr <= cks_pkg::ADDR_RESET;
			fidx <= cks_pkg::IDX_CODE;
			remaining <= cks_pkg::LEN_ZERO;
			mem_req <= 1'b0;
			bad_code <= 1'b0;
		end else begin
			case (state)
				cks_pkg::ST_IDLE: begin
					if (i_start) begin
						state <= cks_pkg::ST_FETCH;
						space_attr <= i_attr_space;
						base <= i_entry_addr;
						addr <= i_entry_addr;
						fidx <= cks_pkg::IDX_CODE;
						mem_req <= 1'b1;
						bad_code <= 1'b0;
					end
				end
				cks_pkg::ST_FETCH: begin
					if (take) begin
						if (fidx == cks_pkg::IDX_CODE && i_mem_data != cks_pkg::CHECKSUM_CODE) begin
							bad_code <= 1'b1;
							mem_req <= 1'b0;
							state <= cks_pkg::ST_DONE;
						end else if (fidx == cks_pkg::IDX_SUM) begin
							addr <= target_addr(base, off_field, space_attr);
							remaining <= len_field;
							mem_req <= (len_field != cks_pkg::LEN_ZERO);
							state <= cks_pkg::ST_SUM;
						end else begin
							addr <= step(addr, space_attr);
							fidx <= fidx + 3'h1;
						end
					end
				end
				cks_pkg::ST_SUM: begin
					if (remaining == cks_pkg::LEN_ZERO) begin
						state <= cks_pkg::ST_DONE;
					end else if (take) begin
						// Even bytes only in attribute space
						addr <= step(addr, space_attr);
						remaining <= remaining - cks_pkg::LEN_ONE;
						if (remaining == cks_pkg::LEN_ONE) begin
							mem_req <= 1'b0;
							state <= cks_pkg::ST_DONE;
						end
					end
				end
				cks_pkg::ST_DONE: begin
					state <= cks_pkg::ST_IDLE;
				end
				default: begin
					state <= cks_pkg::ST_IDLE;
					mem_req <= 1'b0;
				end
			endcase
		end
	end

	// Entry field capture, expected byte included
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			for (int i = 0; i < cks_pkg::ENTRY_BYTES; i++) begin
				fields[i] <= cks_pkg::SUM_RESET;
			end
		end else if (state == cks_pkg::ST_FETCH && take) begin
			fields[fidx] <= i_mem_data;
		end
	end

	sum_accumulator u_acc (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_clear(state == cks_pkg::ST_IDLE && i_start),
		.i_add(state == cks_pkg::ST_SUM && take),
		.i_data(i_mem_data),
		.o_sum(acc_sum)
	);

	// Result
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_done <= 1'b0;
			o_pass <= 1'b0;
			o_fail <= 1'b0;
			o_bad_code <= 1'b0;
		end else begin
			o_done <= (state == cks_pkg::ST_DONE);
			if (state == cks_pkg::ST_IDLE && i_start) begin
				o_pass <= 1'b0;
				o_fail <= 1'b0;
				o_bad_code <= 1'b0;
			end else if (state == cks_pkg::ST_DONE) begin
				o_bad_code <= bad_code;
				o_pass <= !bad_code && (acc_sum == fields[cks_pkg::IDX_SUM]);
				o_fail <= !bad_code && (acc_sum != fields[cks_pkg::IDX_SUM]);
			end
		end
	end

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	a_code_gates_sum: assert property (
		(state == cks_pkg::ST_SUM) |-> (fields[cks_pkg::IDX_CODE] == cks_pkg::CHECKSUM_CODE)
	) else $error("region summed for a non-checksum entry");

	a_bad_code_report: assert property (
		(o_done && o_bad_code) |-> (fields[cks_pkg::IDX_CODE] != cks_pkg::CHECKSUM_CODE)
	) else $error("bad code reported for a checksum entry");

	a_length_bound: assert property (
		(state == cks_pkg::ST_SUM)
			|-> (remaining <= {fields[cks_pkg::IDX_LEN_HI], fields[cks_pkg::IDX_LEN_LO]})
	) else $error("remaining count exceeds length field");

	a_target_common: assert property (
		($rose(state == cks_pkg::ST_SUM) && !space_attr)
			|-> (addr == base + {{(cks_pkg::ADDR_W-16){off_field[15]}}, off_field})
	) else $error("common space target address wrong");

	a_target_attr: assert property (
		($rose(state == cks_pkg::ST_SUM) && space_attr)
			|-> (addr == base + {{(cks_pkg::ADDR_W-17){off_field[15]}}, off_field, 1'b0})
	) else $error("attribute space target address wrong");

	a_attr_even_step: assert property (
		(state == cks_pkg::ST_SUM && take && space_attr && remaining > cks_pkg::LEN_ONE)
			|=> (addr == $past(addr) + cks_pkg::STEP_ATTR)
	) else $error("attribute space region step is not two");

	a_attr_field_even: assert property (
		(state == cks_pkg::ST_FETCH && space_attr)
			|-> (addr == base + {{(cks_pkg::ADDR_W-4){1'b0}}, fidx, 1'b0})
	) else $error("attribute field address not on even byte");

	a_space_stable: assert property (
		(o_mem_req && $past(o_mem_req)) |-> $stable(o_mem_attr)
	) else $error("address space changed during a check");

	a_sum_wraps: assert property (
		(state == cks_pkg::ST_SUM && take)
			|=> (acc_sum == 8'($past(acc_sum) + $past(i_mem_data)))
	) else $error("sum not accumulated modulo 256");

	a_result_compare: assert property (
		(o_done && !o_bad_code) |-> (o_pass == (acc_sum == fields[cks_pkg::IDX_SUM])) && (o_fail == !o_pass)
	) else $error("pass or fail does not match the compare");

	c_pass_common: cover property (o_done && o_pass && !space_attr);
	c_pass_attr: cover property (o_done && o_pass && space_attr);
	c_fail: cover property (o_done && o_fail);
	c_bad_code: cover property (o_done && o_bad_code);
endmodule

// *** bench/card_mem_model.sv ***
// Card memory partner answering byte reads in both spaces
module card_mem_model (
	// Clock
	input wire logic i_mclk,
	// Read port
	input wire logic i_req,
	input wire logic [23:0] i_addr,
	input wire logic i_attr,
	input wire logic i_slow,
	output logic o_ack,
	output logic [7:0] o_data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] attr_mem [4096];
	logic [7:0] comm_mem [4096];
	logic [2:0] wait_cnt = 3'h0;
	initial begin
		o_ack = 1'b0;
		o_data = 8'h00;
	end
	// Separate spaces, one beat per ack
	always @(posedge i_mclk) begin
		if (i_req && !o_ack && (!i_slow || wait_cnt == 3'h3)) begin
			o_ack <= 1'b1;
			o_data <= i_attr ? attr_mem[i_addr[11:0]] : comm_mem[i_addr[11:0]];
			wait_cnt <= 3'h0;
		end else begin
			// Released data toggles so stale bytes never match
			o_ack <= 1'b0;
			o_data <= ~o_data;
			wait_cnt <= i_req ? wait_cnt + 3'h1 : 3'h0;
		end
	end
endmodule

// *** bench/tb.sv ***
// Self-checking bench for the card information checksum checker
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_mclk = 1'b0;
	logic i_rst = 1'b1;
	logic i_start = 1'b0;
	logic [23:0] i_entry_addr = 24'h000000;
	logic i_attr_space = 1'b0;
	logic slow = 1'b0;
	logic req, attr, ack, done, pass, fail, bad, busy;
	logic [23:0] addr;
	logic [7:0] rdata, sum;
	int failures = 0;
	int check_count = 0;
	card_info_checksum_checker dut_u (.i_mclk(i_mclk), .i_rst(i_rst), .i_start(i_start),
		.i_entry_addr(i_entry_addr), .i_attr_space(i_attr_space), .o_mem_req(req),
		.o_mem_addr(addr), .o_mem_attr(attr), .i_mem_ack(ack), .i_mem_data(rdata),
		.o_busy(busy), .o_done(done), .o_pass(pass), .o_fail(fail), .o_bad_code(bad),
		.o_sum(sum));
	card_mem_model mem_u (.i_mclk(i_mclk), .i_req(req), .i_addr(addr), .i_attr(attr),
		.i_slow(slow), .o_ack(ack), .o_data(rdata));
	initial begin
		forever #25 i_mclk = ~i_mclk;
	end
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic put(input logic sp, input logic [23:0] a, input logic [7:0] v);
		if (sp) begin
			mem_u.attr_mem[a[11:0]] = v;
			mem_u.attr_mem[a[11:0] + 12'h001] = 8'h77;
		end else begin
			mem_u.comm_mem[a[11:0]] = v;
		end
	endtask
	always @(negedge i_mclk) begin
		if (req) begin
			check("space", {6'h00, attr, addr[0] & i_attr_space}, {6'h00, i_attr_space, 1'b0});
		end
	end
	task automatic run(input logic [23:0] base, input logic sp, input logic [15:0] off,
		input logic [15:0] len, input logic [7:0] code, input logic good);
		logic [7:0] f [6];
		logic [23:0] st;
		logic [23:0] p;
		logic [7:0] s;
		logic [7:0] v;
		int n;
		f = '{code, 8'h05, off[7:0], off[15:8], len[7:0], len[15:8]};
		st = sp ? 24'h000002 : 24'h000001;
		p = base;
		for (n = 0; n < 6; n++) begin
			put(sp, p, f[n]);
			p += st;
		end
		put(sp, p, 8'h00);
		p = base + ({{8{off[15]}}, off} << sp);
		s = 8'h00;
		v = 8'h91;
		for (n = 0; n < int'(len); n++) begin
			put(sp, p, v);
			put(!sp, p, ~v);
			s += v;
			v += 8'h0D;
			p += st;
		end
		put(sp, base + st * 24'h000006, good ? s : s + 8'h01);
		@(negedge i_mclk);
		i_entry_addr = base;
		i_attr_space = sp;
		i_start = 1'b1;
		@(negedge i_mclk);
		i_start = 1'b0;
		check("busy start", {7'h00, busy}, 8'h01);
		n = 0;
		while (done !== 1'b1) begin
			@(negedge i_mclk);
			n++;
			if (n > 5000) begin
				failures++;
				conclude();
			end
		end
		check("busy end", {7'h00, busy}, 8'h00);
		check("bad", {7'h00, bad}, {7'h00, code != 8'h10});
		check("pass", {7'h00, pass}, {7'h00, code == 8'h10 && good});
		check("fail", {7'h00, fail}, {7'h00, code == 8'h10 && !good});
		if (code == 8'h10) begin
			check("sum", sum, s);
		end else begin
			check("sum skipped", sum, 8'h00);
		end
	endtask
	task automatic idle_checks();
		check("rst req", {7'h00, req}, 8'h00);
		check("rst busy", {7'h00, busy}, 8'h00);
		check("rst done", {7'h00, done}, 8'h00);
		check("rst pass fail", {6'h00, pass, fail}, 8'h00);
		check("rst bad", {7'h00, bad}, 8'h00);
		check("rst sum", sum, 8'h00);
	endtask
	task automatic t_reset_idle();
		idle_checks();
		$display("test reset idle done");
	endtask
	task automatic t_reset_mid();
		put(1'b0, 24'h000500, 8'h10);
		@(negedge i_mclk);
		i_entry_addr = 24'h000500;
		i_attr_space = 1'b0;
		i_start = 1'b1;
		@(negedge i_mclk);
		i_start = 1'b0;
		repeat (4) @(negedge i_mclk);
		i_rst = 1'b1;
		repeat (2) @(negedge i_mclk);
		i_rst = 1'b0;
		idle_checks();
		$display("test reset mid-run done");
	endtask
	task automatic t_common_pos();
		run(24'h000010, 1'b0, 16'h0020, 16'h012C, 8'h10, 1'b1);
		$display("test common positive done");
	endtask
	task automatic t_common_neg_slow();
		slow = 1'b1;
		run(24'h000800, 1'b0, 16'hFF00, 16'h0009, 8'h10, 1'b0);
		slow = 1'b0;
		$display("test common negative slow done");
	endtask
	task automatic t_attr_pos();
		run(24'h000C00, 1'b1, 16'h0008, 16'h000C, 8'h10, 1'b1);
		$display("test attribute positive done");
	endtask
	task automatic t_attr_neg();
		run(24'h000E00, 1'b1, 16'hFFF0, 16'h0008, 8'h10, 1'b0);
		$display("test attribute negative done");
	endtask
	task automatic t_zero_len();
		run(24'h000300, 1'b0, 16'h0010, 16'h0000, 8'h10, 1'b1);
		$display("test zero length done");
	endtask
	task automatic t_bad_code();
		run(24'h000400, 1'b0, 16'h0010, 16'h0004, 8'h11, 1'b1);
		$display("test foreign code done");
	endtask
	initial begin
		repeat (16) @(negedge i_mclk);
		i_rst = 1'b0;
		t_reset_idle();
		t_common_pos();
		t_common_neg_slow();
		t_reset_mid();
		t_attr_pos();
		t_attr_neg();
		t_zero_len();
		t_bad_code();
		conclude();
	end
endmodule
